// [trap_unit_pkg.sv]
// trap_unit_pkg: constants, codes and carrier types of the trap and interrupt entry unit.
// assumes a 32-bit core with 32-bit status words and a 16-level interrupt input.
package trap_unit_pkg;

  // register word offsets on the plain register port
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_ORD_PC = 8'h04;
  localparam logic [7:0] OFF_ORD_ST = 8'h08;
  localparam logic [7:0] OFF_FAT_PC = 8'h0C;
  localparam logic [7:0] OFF_FAT_ST = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [7:0] OFF_EVT = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;

  // status word flag positions and reset value, then the select bit of the control word
  localparam int unsigned DIS_BIT = 12;
  localparam int unsigned EXCPEND_BIT = 14;
  localparam int unsigned FATPEND_BIT = 15;
  localparam logic [31:0] STATUS_RESET = 32'h0000_1000;
  localparam int unsigned HISEL_BIT = 0;

  // event bits of the sticky event register
  localparam int unsigned EVT_ENTRY = 0;
  localparam int unsigned EVT_RETURN = 1;
  localparam int unsigned EVT_SEVERE = 2;
  localparam int unsigned EVT_W = 3;

  // cause codes and handler addresses
  localparam logic [15:0] CAUSE_RESET = 16'hFFF0;
  localparam logic [15:0] CAUSE_NMI = 16'hFFD0;
  localparam logic [15:0] CAUSE_TRAP = 16'hFFA0;
  localparam logic [15:0] CAUSE_INVALID = 16'hFF90;
  localparam logic [15:0] CAUSE_DIVZERO = 16'hFF80;
  localparam logic [15:0] CAUSE_INT = 16'hFE00;
  localparam logic [31:0] VEC_RESET = 32'hFFFF_FFF0;
  localparam logic [31:0] VEC_FATAL = 32'hFFFF_FFE0;
  localparam logic [31:0] VEC_NMI = 32'hFFFF_FFD0;
  localparam logic [31:0] VEC_TRAP = 32'hFFFF_FFA0;
  localparam logic [31:0] VEC_INVALID = 32'hFFFF_FF90;
  localparam logic [31:0] VEC_DIVZERO = 32'hFFFF_FF80;
  localparam logic [31:0] VEC_INT_LO = 32'hFFFF_FE00;
  localparam logic [31:0] VEC_INT_HI = 32'hFE00_0000;

  typedef enum logic [2:0] {
    EV_NONE = 3'h0, EV_RESET = 3'h1, EV_FATAL = 3'h2, EV_NMI = 3'h3,
    EV_INT = 3'h4, EV_TRAP = 3'h5, EV_INVALID = 3'h6, EV_DIVZERO = 3'h7
  } kind_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SAVE = 2'b01, ST_JUMP = 2'b11
  } state_type;

  // exception requests raised by the instruction at the boundary
  typedef struct packed {
    logic fatal;
    logic trap;
    logic [4:0] trap_vec;
    logic invalid;
    logic divzero;
  } req_type;

  // the chosen event and how it is to be entered
  typedef struct packed {
    kind_type kind;
    logic [15:0] cause;
    logic [31:0] vector;
    logic to_fatal;
    logic use_next;
    logic write_cause;
  } entry_type;

endpackage

// [event_ranker.sv]
// event_ranker: picks the highest ranked pending event and decodes its codes.
// assumes all inputs are stable in the cycle the caller samples the result.
`timescale 1ns/10ps
`default_nettype none
module event_ranker import trap_unit_pkg::*; (
  input wire logic reset_pend,
  input wire req_type req,
  input wire logic nmi_req,
  input wire logic int_req,
  input wire logic [3:0] int_level,
  input wire logic [31:0] status,
  input wire logic hi_sel,
  output entry_type sel
);

  // one place for packing an entry
  function automatic entry_type make(input kind_type k, input logic [15:0] c,
                                     input logic [31:0] v, input logic f,
                                     input logic n, input logic w);
    make = '{kind: k, cause: c, vector: v, to_fatal: f, use_next: n, write_cause: w};
  endfunction

  logic nested;
  logic int_ok;
  logic nmi_ok;
  assign nested = status[EXCPEND_BIT];
  // maskable requests wait while any handler is running
  assign int_ok = int_req && !status[DIS_BIT] && !nested && !status[FATPEND_BIT];
  assign nmi_ok = nmi_req && !status[FATPEND_BIT];

  // rank: reset, fatal, nmi, level, then instruction exceptions
  always_comb begin
    sel = make(EV_NONE, 16'h0000, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
    if (reset_pend) begin
      sel = make(EV_RESET, CAUSE_RESET, VEC_RESET, 1'b0, 1'b0, 1'b1);
    end else if (req.fatal) begin
      sel = make(EV_FATAL, 16'h0000, VEC_FATAL, 1'b1, 1'b0, 1'b0);
    end else if (nmi_ok) begin
      sel = make(EV_NMI, CAUSE_NMI, VEC_NMI, 1'b1, 1'b1, 1'b1);
    end else if (int_ok) begin
      sel = make(EV_INT, CAUSE_INT | {8'h00, int_level, 4'h0},
                 (hi_sel ? VEC_INT_HI : VEC_INT_LO) | {24'h0, int_level, 4'h0},
                 1'b0, 1'b1, 1'b1);
    end else if (req.trap) begin
      sel = make(EV_TRAP, CAUSE_TRAP + {11'h000, req.trap_vec},
                 VEC_TRAP + {27'h0, req.trap_vec[4], 4'h0}, nested, 1'b1, 1'b1);
    end else if (req.invalid) begin
      // a second exception while exception-pending is set is a double exception
      sel = make(EV_INVALID, CAUSE_INVALID, nested ? VEC_NMI : VEC_INVALID, nested, 1'b0, 1'b1);
    end else if (req.divzero) begin
      sel = make(EV_DIVZERO, CAUSE_DIVZERO, nested ? VEC_NMI : VEC_DIVZERO, nested, 1'b0, 1'b1);
    end
  end

endmodule
`default_nettype wire

// [trap_entry_unit.sv]
// trap_entry_unit: exception and interrupt entry, save registers, cause register,
// return from exception, and the software register port with its interrupt.
// assumes the pipeline holds at a boundary while busy is high and obeys redirects.
`timescale 1ns/10ps
`default_nettype none
// Function
// - interrupts are served before ordinary exceptions when both wait
// - a fatal exception beats every interrupt, the non-maskable one too
// - trap writes its code to fatal cause field if pending flag set
// - trap saves pc and status to fatal pair if pending, else ordinary
// - trap sets fatal-pending and disable, or exception-pending and disable
// - trap then jumps to the handler picked by its vector operand
// - codes for invalid opcode, divide by zero and both trap vector groups
// - reset and non-maskable codes and vectors; fatal vectors without code
// - level interrupt code depends on level only, vector on level and address select
// - saved pc is next or current instruction depending on the event
// - maskable levelled and non-maskable requests arrive independently
// - return restores pc and status word from the save registers
module trap_entry_unit import trap_unit_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boundary,
  input wire logic [31:0] cur_pc,
  input wire logic [31:0] next_pc,
  input wire req_type req,
  input wire logic ret_req,
  input wire logic nmi_req,
  input wire logic int_req,
  input wire logic [3:0] int_level,
  output logic busy,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [31:0] status_word,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);

  state_type state_q, state_d;
  entry_type entry_q, entry_d, sel;
  logic reset_pend_q, reset_pend_d;
  logic [31:0] src_pc_q, src_pc_d;
  logic [31:0] cause_q, cause_d;
  logic [31:0] ord_pc_q, ord_pc_d, ord_st_q, ord_st_d;
  logic [31:0] fat_pc_q, fat_pc_d, fat_st_q, fat_st_d;
  logic [31:0] status_q, status_d;
  logic hi_sel_q, hi_sel_d;
  logic [EVT_W-1:0] evt_q, evt_d, mask_q, mask_d, evt_set;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] redir_q, redir_d;
  logic take;
  logic ret_take;

  event_ranker u_rank (
    .reset_pend(reset_pend_q),
    .req(req),
    .nmi_req(nmi_req),
    .int_req(int_req),
    .int_level(int_level),
    .status(status_q),
    .hi_sel(hi_sel_q),
    .sel(sel)
  );

  // entries start only from idle at a boundary; reset entry needs no boundary
  assign take = (state_q == ST_IDLE) && (sel.kind != EV_NONE)
                && (boundary || reset_pend_q);
  assign ret_take = (state_q == ST_IDLE) && boundary && ret_req && !take;
  assign busy = (state_q != ST_IDLE);
  assign redirect_valid = (state_q == ST_JUMP);
  assign redirect_pc = redir_q;
  assign status_word = status_q;
  assign rdata = rdata_q;
  assign irq = |(evt_q & mask_q);

  // register port: bus writes first, hardware updates after so they win
  always_comb begin
    state_d = state_q;
    entry_d = entry_q;
    reset_pend_d = reset_pend_q;
    src_pc_d = src_pc_q;
    cause_d = cause_q;
    ord_pc_d = ord_pc_q;
    ord_st_d = ord_st_q;
    fat_pc_d = fat_pc_q;
    fat_st_d = fat_st_q;
    status_d = status_q;
    hi_sel_d = hi_sel_q;
    mask_d = mask_q;
    redir_d = redir_q;
    evt_set = '0;
    rdata_d = 32'h0000_0000;
    if (wr) begin
      case (addr)
        OFF_ORD_PC: ord_pc_d = wdata;
        OFF_ORD_ST: ord_st_d = wdata;
        OFF_FAT_PC: fat_pc_d = wdata;
        OFF_FAT_ST: fat_st_d = wdata;
        OFF_STATUS: status_d = wdata;
        OFF_CTRL: hi_sel_d = wdata[HISEL_BIT];
        OFF_MASK: mask_d = wdata[EVT_W-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        OFF_CAUSE: rdata_d = cause_q;
        OFF_ORD_PC: rdata_d = ord_pc_q;
        OFF_ORD_ST: rdata_d = ord_st_q;
        OFF_FAT_PC: rdata_d = fat_pc_q;
        OFF_FAT_ST: rdata_d = fat_st_q;
        OFF_STATUS: rdata_d = status_q;
        OFF_CTRL: rdata_d = {31'h0, hi_sel_q};
        OFF_EVT: rdata_d = {29'h0, evt_q};
        OFF_MASK: rdata_d = {29'h0, mask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          entry_d = sel;
          reset_pend_d = 1'b0;
          src_pc_d = sel.use_next ? next_pc : cur_pc;
          state_d = ST_SAVE;
        end else if (ret_take) begin
          // the fatal pair is live while a fatal-level handler runs
          redir_d = status_q[FATPEND_BIT] ? fat_pc_q : ord_pc_q;
          status_d = status_q[FATPEND_BIT] ? fat_st_q : ord_st_q;
          evt_set[EVT_RETURN] = 1'b1;
          state_d = ST_JUMP;
        end
      end
      ST_SAVE: begin
        // save, code and flags land together; nothing can split them
        if (entry_q.kind == EV_RESET) begin
          status_d = STATUS_RESET;
        end else if (entry_q.to_fatal) begin
          fat_pc_d = src_pc_q;
          fat_st_d = status_q;
          status_d[FATPEND_BIT] = 1'b1;
          status_d[DIS_BIT] = 1'b1;
        end else begin
          ord_pc_d = src_pc_q;
          ord_st_d = status_q;
          status_d[EXCPEND_BIT] = 1'b1;
          status_d[DIS_BIT] = 1'b1;
        end
        if (entry_q.write_cause && entry_q.to_fatal) begin
          cause_d[31:16] = entry_q.cause;
        end else if (entry_q.write_cause) begin
          cause_d[15:0] = entry_q.cause;
        end
        redir_d = entry_q.vector;
        evt_set[EVT_ENTRY] = 1'b1;
        evt_set[EVT_SEVERE] = entry_q.to_fatal;
        state_d = ST_JUMP;
      end
      ST_JUMP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // write one to clear; a new event in the same cycle keeps its bit
    evt_d = evt_q;
    if (wr && (addr == OFF_EVT)) begin
      evt_d = evt_q & ~wdata[EVT_W-1:0];
    end
    evt_d = evt_d | evt_set;
  end

  // state registers; reset starts the reset entry sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      entry_q <= '0;
      reset_pend_q <= 1'b1;
      src_pc_q <= 32'h0000_0000;
      cause_q <= 32'h0000_0000;
      ord_pc_q <= 32'h0000_0000;
      ord_st_q <= 32'h0000_0000;
      fat_pc_q <= 32'h0000_0000;
      fat_st_q <= 32'h0000_0000;
      status_q <= STATUS_RESET;
      hi_sel_q <= 1'b0;
      evt_q <= '0;
      mask_q <= '0;
      rdata_q <= 32'h0000_0000;
      redir_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      entry_q <= entry_d;
      reset_pend_q <= reset_pend_d;
      src_pc_q <= src_pc_d;
      cause_q <= cause_d;
      ord_pc_q <= ord_pc_d;
      ord_st_q <= ord_st_d;
      fat_pc_q <= fat_pc_d;
      fat_st_q <= fat_st_d;
      status_q <= status_d;
      hi_sel_q <= hi_sel_d;
      evt_q <= evt_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      redir_q <= redir_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_save_then_jump;
    state_q == ST_SAVE ##1 (redirect_valid && redirect_pc == entry_q.vector);
  endsequence

  sequence s_back_idle;
    state_q == ST_IDLE && !redirect_valid;
  endsequence

  int_first_a: assert property (
    (take && !reset_pend_q && !req.fatal && !nmi_req && int_req && req.invalid
     && !status_q[DIS_BIT] && !status_q[EXCPEND_BIT] && !status_q[FATPEND_BIT])
    |=> entry_q.kind == EV_INT)
    else $error("interrupt lost priority to exception");

  fatal_first_a: assert property (
    (take && !reset_pend_q && req.fatal && nmi_req) |=> entry_q.kind == EV_FATAL)
    else $error("fatal exception did not win");

  trap_cause_a: assert property (
    (state_q == ST_SAVE && entry_q.kind == EV_TRAP && status_q[EXCPEND_BIT])
    |=> cause_q[31:16] == $past(entry_q.cause) && $stable(cause_q[15:0]))
    else $error("trap code in wrong field");

  trap_save_a: assert property (
    (state_q == ST_SAVE && entry_q.kind == EV_TRAP && !status_q[EXCPEND_BIT])
    |=> ord_pc_q == $past(src_pc_q) && ord_st_q == $past(status_q))
    else $error("trap state not saved to ordinary pair");

  trap_flags_a: assert property (
    (state_q == ST_SAVE && entry_q.kind == EV_TRAP && status_q[EXCPEND_BIT])
    |=> status_q[FATPEND_BIT] && status_q[DIS_BIT])
    else $error("fatal-pending flags not set");

  entry_seq_a: assert property (
    take |=> s_save_then_jump ##1 s_back_idle)
    else $error("entry sequence broken");

  invalid_code_a: assert property (
    (take && sel.kind == EV_INVALID && !status_q[EXCPEND_BIT])
    |=> ##1 cause_q[15:0] == CAUSE_INVALID && redirect_pc == VEC_INVALID)
    else $error("invalid opcode code or vector wrong");

  int_vector_a: assert property (
    (take && sel.kind == EV_INT && hi_sel_q)
    |=> ##1 redirect_pc == (VEC_INT_HI | {24'h0, $past(int_level, 2), 4'h0}))
    else $error("level interrupt vector wrong");

  next_pc_a: assert property (
    (take && sel.kind == EV_NMI) |=> ##1 fat_pc_q == $past(next_pc, 2))
    else $error("nmi saved wrong pc");

  return_from_exception_a: assert property (
    (ret_take && !status_q[FATPEND_BIT])
    |=> redirect_valid && redirect_pc == $past(ord_pc_q)
        && status_q == $past(ord_st_q))
    else $error("return did not restore");

  // codes, vectors and saved pcs of the entries that the checks above leave open
  reset_entry_a: assert property (
    (take && reset_pend_q) |=> ##1 redirect_valid && redirect_pc == VEC_RESET
        && cause_q[15:0] == CAUSE_RESET && status_q == STATUS_RESET)
    else $error("reset entry wrong");

  nmi_code_a: assert property (
    (take && sel.kind == EV_NMI)
    |=> ##1 cause_q[31:16] == CAUSE_NMI && redirect_pc == VEC_NMI)
    else $error("nmi code or vector wrong");

  fatal_entry_a: assert property (
    (take && sel.kind == EV_FATAL)
    |=> ##1 redirect_pc == VEC_FATAL && $stable(cause_q) && fat_pc_q == $past(cur_pc, 2))
    else $error("fatal entry wrong");

  // the non-maskable request is only held off by a running fatal-level handler
  nmi_accept_a: assert property (
    (take && !reset_pend_q && !req.fatal && nmi_req && !status_q[FATPEND_BIT])
    |=> entry_q.kind == EV_NMI)
    else $error("non-maskable request not taken");

  double_exc_a: assert property (
    (take && sel.kind == EV_INVALID && status_q[EXCPEND_BIT])
    |=> ##1 fat_pc_q == $past(cur_pc, 2) && redirect_pc == VEC_NMI)
    else $error("double exception entry wrong");

  int_code_a: assert property (
    (take && sel.kind == EV_INT)
    |=> ##1 cause_q[15:0] == (CAUSE_INT | {8'h00, $past(int_level, 2), 4'h0}))
    else $error("level interrupt code wrong");

endmodule
`default_nettype wire

// [pipe_model.sv]
// pipe_model: pipeline and request sources facing the entry unit.
// assumes the bench pulses go for one cycle only while the unit is idle.
`timescale 1ns/10ps
`default_nettype none
module pipe_model import trap_unit_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic go,
  input wire req_type go_req,
  input wire logic [2:0] go_ev,
  input wire logic [3:0] go_lvl,
  input wire logic [31:0] go_pc,
  output logic boundary,
  output logic [31:0] cur_pc,
  output logic [31:0] next_pc,
  output req_type req,
  output logic ret_req,
  output logic nmi_req,
  output logic int_req,
  output logic [3:0] int_level
);
  // requests hold at the boundary until the unit turns busy, then all drop
  always @(posedge clk) begin
    if (!rst_n) begin
      boundary <= 1'b0;
      req <= '0;
      ret_req <= 1'b0;
      nmi_req <= 1'b0;
      int_req <= 1'b0;
      int_level <= 4'h0;
      cur_pc <= 32'h0000_0000;
      next_pc <= 32'h0000_0000;
    end else if (busy) begin
      boundary <= 1'b0;
      req <= '0;
      ret_req <= 1'b0;
      nmi_req <= 1'b0;
      int_req <= 1'b0;
      int_level <= ~int_level; // released lines toggle so stale values never match
      cur_pc <= ~cur_pc;
      next_pc <= ~next_pc;
    end else if (go) begin
      boundary <= 1'b1;
      req <= go_req;
      ret_req <= go_ev[2];
      nmi_req <= go_ev[1];
      int_req <= go_ev[0];
      int_level <= go_lvl;
      cur_pc <= go_pc;
      next_pc <= go_pc + 32'h0000_0004;
    end
  end
endmodule
`default_nettype wire

// [trap_entry_unit_test.sv]
// trap_entry_unit_test: directed scenarios for entry, return and the register port.
// assumes pipe_model stands in for the pipeline and the request sources.
`timescale 1ns/10ps
`default_nettype none
module trap_entry_unit_test import trap_unit_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  req_type go_req = '0;
  logic [2:0] go_ev = 3'h0;
  logic [3:0] go_lvl = 4'h0;
  logic [31:0] go_pc = 32'h0000_0000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic boundary, ret_req, nmi_req, int_req, busy, redirect_valid, irq;
  logic [31:0] cur_pc, next_pc, redirect_pc, status_word, rdata;
  logic [3:0] int_level;
  req_type req;
  int num_errors = 0;
  int num_checks = 0;
  localparam req_type NO_REQ = '0;

  always #5 clk = ~clk;

  pipe_model model (.clk(clk), .rst_n(rst_n), .busy(busy), .go(go), .go_req(go_req),
    .go_ev(go_ev), .go_lvl(go_lvl), .go_pc(go_pc), .boundary(boundary), .cur_pc(cur_pc),
    .next_pc(next_pc), .req(req), .ret_req(ret_req), .nmi_req(nmi_req), .int_req(int_req),
    .int_level(int_level));

  trap_entry_unit dut (.clk(clk), .rst_n(rst_n), .boundary(boundary), .cur_pc(cur_pc),
    .next_pc(next_pc), .req(req), .ret_req(ret_req), .nmi_req(nmi_req), .int_req(int_req),
    .int_level(int_level), .busy(busy), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .status_word(status_word), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle strobes, launched just after an edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_rv();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (redirect_valid !== 1'b1 && n < 20);
    chk("redirect pulse", {31'h0, redirect_valid}, 32'h0000_0001);
    chk("busy at redirect", {31'h0, busy}, 32'h0000_0001);
  endtask

  // hands one boundary to the model and checks where fetch is sent
  task automatic ev(input req_type r, input logic [2:0] e, input logic [3:0] l,
                    input logic [31:0] pc, input logic [31:0] exp, input string nm);
    @(posedge clk);
    go <= 1'b1;
    go_req <= r;
    go_ev <= e;
    go_lvl <= l;
    go_pc <= pc;
    @(posedge clk);
    go <= 1'b0;
    wait_rv();
    chk(nm, redirect_pc, exp);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] v;
    rd_reg(a, v);
    chk(nm, v, exp);
  endtask

  task automatic t_reset();
    logic [31:0] v;
    wait_rv();
    chk("reset vector", redirect_pc, VEC_RESET);
    rd_reg(OFF_CAUSE, v);
    chk("reset cause", {16'h0000, v[15:0]}, {16'h0000, CAUSE_RESET});
    chk("reset status", status_word, STATUS_RESET);
    wr_reg(OFF_STATUS, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_trap_pair();
    logic [31:0] v;
    ev('{0, 1, 5'h13, 0, 0}, 3'h0, 4'h0, 32'h100, 32'hFFFF_FFB0, "trap 13");
    rd_chk(OFF_ORD_PC, 32'h0000_0104, "ordinary pc");
    rd_chk(OFF_ORD_ST, 32'h0000_0000, "ordinary status");
    rd_reg(OFF_CAUSE, v);
    chk("ordinary cause", {16'h0000, v[15:0]}, 32'h0000_FFB3);
    chk("flags ep id", status_word, 32'h0000_5000);
    ev('{0, 1, 5'h05, 0, 0}, 3'h0, 4'h0, 32'h200, 32'hFFFF_FFA0, "trap 05");
    rd_chk(OFF_FAT_PC, 32'h0000_0204, "fatal pc");
    rd_chk(OFF_FAT_ST, 32'h0000_5000, "fatal status");
    rd_reg(OFF_CAUSE, v);
    chk("fatal cause", {16'h0000, v[31:16]}, 32'h0000_FFA5);
    chk("flags np id", status_word, 32'h0000_D000);
    $display("test trap pairs done");
  endtask

  task automatic t_return();
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0204, "return fatal");
    chk("status from fatal", status_word, 32'h0000_5000);
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0104, "return ordinary");
    chk("status from ordinary", status_word, 32'h0000_0000);
    $display("test return done");
  endtask

  task automatic t_priority();
    logic [31:0] v;
    ev('{1, 0, 5'h00, 0, 0}, 3'h3, 4'h3, 32'h300, VEC_FATAL, "fatal first");
    rd_chk(OFF_FAT_PC, 32'h0000_0300, "fatal current pc");
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0300, "return 1");
    ev('{0, 0, 5'h00, 1, 0}, 3'h3, 4'h3, 32'h400, VEC_NMI, "nmi first");
    rd_chk(OFF_FAT_PC, 32'h0000_0404, "nmi next pc");
    rd_reg(OFF_CAUSE, v);
    chk("nmi cause", {16'h0000, v[31:16]}, {16'h0000, CAUSE_NMI});
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0404, "return 2");
    ev('{0, 1, 5'h02, 1, 0}, 3'h1, 4'h5, 32'h500, 32'hFFFF_FE50, "int first");
    rd_chk(OFF_ORD_PC, 32'h0000_0504, "int next pc");
    rd_reg(OFF_CAUSE, v);
    chk("int cause", {16'h0000, v[15:0]}, 32'h0000_FE50);
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0504, "return 3");
    $display("test priority done");
  endtask

  task automatic t_levels();
    wr_reg(OFF_CTRL, 32'h0000_0001);
    ev(NO_REQ, 3'h1, 4'hA, 32'h600, 32'hFE00_00A0, "int a high map");
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0604, "return 4");
    wr_reg(OFF_CTRL, 32'h0000_0000);
    ev(NO_REQ, 3'h1, 4'hF, 32'h680, 32'hFFFF_FEF0, "int f low map");
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0684, "return 5");
    $display("test levels done");
  endtask

  // invalid opcode then divide by zero, both saving the current pc
  task automatic t_codes();
    logic [31:0] v;
    req_type rq [2];
    logic [31:0] vec [2];
    logic [15:0] code [2];
    rq = '{'{0, 0, 5'h00, 1, 0}, '{0, 0, 5'h00, 0, 1}};
    vec = '{VEC_INVALID, VEC_DIVZERO};
    code = '{CAUSE_INVALID, CAUSE_DIVZERO};
    for (int i = 0; i < 2; i++) begin
      ev(rq[i], 3'h0, 4'h0, 32'h700 + 32'(i), vec[i], "code vector");
      rd_chk(OFF_ORD_PC, 32'h700 + 32'(i), "code current pc");
      rd_reg(OFF_CAUSE, v);
      chk("code cause", {16'h0000, v[15:0]}, {16'h0000, code[i]});
      ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h700 + 32'(i), "return 6");
    end
    // an invalid opcode inside a running handler becomes a double exception
    ev('{0, 1, 5'h02, 0, 0}, 3'h0, 4'h0, 32'h800, 32'hFFFF_FFA0, "trap 02");
    ev(rq[0], 3'h0, 4'h0, 32'h810, VEC_NMI, "double vector");
    rd_chk(OFF_FAT_PC, 32'h0000_0810, "double current pc");
    rd_reg(OFF_CAUSE, v);
    chk("double cause", {16'h0000, v[31:16]}, {16'h0000, CAUSE_INVALID});
    chk("double flags", status_word, 32'h0000_D000);
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0810, "return double");
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0804, "return trap");
    $display("test codes done");
  endtask

  task automatic t_irq();
    logic [31:0] v;
    wr_reg(OFF_MASK, 32'h0000_0000);
    wr_reg(OFF_EVT, 32'h0000_0007);
    rd_chk(OFF_EVT, 32'h0000_0000, "events cleared");
    ev('{0, 1, 5'h01, 0, 0}, 3'h0, 4'h0, 32'hA00, 32'hFFFF_FFA0, "trap 01");
    rd_chk(OFF_EVT, 32'h0000_0001, "entry event");
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr_reg(OFF_MASK, 32'h0000_0001);
    chk("irq unmasked", {31'h0, irq}, 32'h0000_0001);
    wr_reg(OFF_EVT, 32'h0000_0001);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    ev(NO_REQ, 3'h4, 4'h0, 32'h900, 32'h0000_0A04, "return 7");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    rd_reg(OFF_CAUSE, v);
    wr_reg(OFF_CAUSE, 32'h0000_0000);
    rd_chk(OFF_CAUSE, v, "cause read only");
    $display("test register port done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_trap_pair();
    t_return();
    t_priority();
    t_levels();
    t_codes();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
